/* pkg/psm_pkg.sv */
package psm_pkg;
   // register byte offsets
   localparam logic [3:0] REG_MCSR_OFS = 4'h0;
   localparam logic [3:0] REG_STAT_OFS = 4'h4;
   localparam logic [3:0] REG_CFG_OFS = 4'h8;
   // main clock status register fields
   localparam int SMS_BIT = 0;
   localparam int CPX_LSB = 1;
   localparam int OIE_BIT = 3;
   localparam logic [3:0] MCSR_RESET = 4'h0;
   // status register fields
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_OSC_BIT = 3;
   localparam int STAT_SLOW_BIT = 4;
   // config register: stabilisation length select
   localparam int CFG_LONG_BIT = 0;
   localparam logic CFG_RESET = 1'b1;
   // condition code mask forced on wait/halt entry
   localparam logic [1:0] MASK_ALL_EN = 2'h2;
   // oscillator stabilisation delays in master clock cycles
   localparam int STAB_SHORT_CYC = 256;
   localparam int STAB_LONG_CYC = 4096;
   localparam int STAB_W = 13;
   // pins that can end halt, and sync depth
   localparam int WAKE_W = 4;
   localparam int SYNC_DEPTH = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [2:0] {
      PM_RUN,
      PM_WAIT,
      PM_AHALT,
      PM_HALT,
      PM_STAB
   } psm_mode_type;
endpackage

/* rtl/psm_clk_div.sv */
`timescale 1ns/1ps
`default_nettype none
module psm_clk_div
   import psm_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic slow_en_i,
   input wire logic [1:0] div_sel_i,
   output logic tick_o
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [3:0] last_w;
   logic wrap_w;
   logic tick_d;

   // divisor 2^(sel+1): 2, 4, 8 or 16
   assign last_w = 4'((5'h2 << div_sel_i) - 5'h1);
   assign wrap_w = (cnt_q >= last_w);
   assign cnt_d = (!slow_en_i || wrap_w) ? 4'h0 : cnt_q + 4'h1;
   // full master clock when slow mode is off
   assign tick_d = !slow_en_i || wrap_w;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_q <= 4'h0;
         // full rate straight out of reset, so the cpu clock runs on the first edge
         tick_o <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         tick_o <= tick_d;
      end
   end
endmodule
`default_nettype wire

/* rtl/psm_ctrl.sv */
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module psm_ctrl
   import psm_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // axi4-lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // cpu core side, same clock
   input wire logic wfi_exec_i,
   input wire logic halt_exec_i,
   input wire logic irq_pending_i,
   input wire logic tb_irq_i,
   input wire logic css_irq_i,
   input wire logic wdg_active_i,
   input wire logic watchdog_halt_option_i,
   // pins, asynchronous
   input wire logic [WAKE_W-1:0] ext_wake_i,
   input wire logic ext_rst_req_i,
   // control outputs
   output logic cpu_clk_en_o,
   output logic periph_clk_en_o,
   output logic tb_clk_en_o,
   output logic osc_en_o,
   output logic mask_force_o,
   output logic [1:0] mask_value_o,
   output logic irq_service_o,
   output logic rst_vector_o,
   output logic wdg_reset_o,
   output logic [2:0] mode_o
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   localparam int NSYNC = WAKE_W + 1;
   logic [NSYNC-1:0] pin_raw_w;
   logic [NSYNC-1:0] pin_s1_q;
   logic [NSYNC-1:0] pin_s2_q;
   logic [NSYNC-1:0] pin_s3_q;
   logic [NSYNC-1:0] pin_q;

   assign pin_raw_w = {ext_rst_req_i, ext_wake_i};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge core_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               pin_s1_q[gi] <= 1'b0;
               pin_s2_q[gi] <= 1'b0;
               pin_s3_q[gi] <= 1'b0;
               pin_q[gi] <= 1'b0;
            end else begin
               pin_s1_q[gi] <= pin_raw_w[gi];
               pin_s2_q[gi] <= pin_s1_q[gi];
               pin_s3_q[gi] <= pin_s2_q[gi];
               // a change counts only once stages two and three agree
               if (pin_s2_q[gi] == pin_s3_q[gi]) begin
                  pin_q[gi] <= pin_s3_q[gi];
               end
            end
         end
      end
   endgenerate

   logic ext_wake_w;
   logic ext_rst_w;
   assign ext_wake_w = |pin_q[WAKE_W-1:0];
   assign ext_rst_w = pin_q[WAKE_W];

   ////////////////////////////////////////////////////////////////////////////
   // register bus
   logic [3:0] mcsr_q;
   logic cfg_long_q;
   logic aw_held_q;
   logic w_held_q;
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   psm_mode_type mode_q;
   psm_mode_type mode_d;

   logic aw_take_w;
   logic w_take_w;
   logic wr_fire_w;
   logic ar_take_w;
   logic wr_mcsr_w;
   logic wr_cfg_w;
   logic wr_hit_w;
   logic rd_hit_w;
   logic [31:0] rd_word_w;

   assign aw_take_w = s_axi_awvalid && s_axi_awready;
   assign w_take_w = s_axi_wvalid && s_axi_wready;
   assign wr_fire_w = aw_held_q && w_held_q && !s_axi_bvalid;
   assign ar_take_w = s_axi_arvalid && s_axi_arready;
   assign wr_mcsr_w = wr_fire_w && (awaddr_q == REG_MCSR_OFS) && wstrb_q[0];
   assign wr_cfg_w = wr_fire_w && (awaddr_q == REG_CFG_OFS) && wstrb_q[0];
   assign wr_hit_w = (awaddr_q == REG_MCSR_OFS) || (awaddr_q == REG_STAT_OFS) ||
      (awaddr_q == REG_CFG_OFS);
   assign rd_hit_w = (s_axi_araddr == REG_MCSR_OFS) || (s_axi_araddr == REG_STAT_OFS) ||
      (s_axi_araddr == REG_CFG_OFS);
   assign rd_word_w = (s_axi_araddr == REG_MCSR_OFS) ? {28'h0, mcsr_q} :
      (s_axi_araddr == REG_STAT_OFS) ? {27'h0, mode_q != PM_RUN && mcsr_q[SMS_BIT],
         osc_en_o, mode_q} :
      (s_axi_araddr == REG_CFG_OFS) ? {31'h0, cfg_long_q} : 32'h0;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else begin
         if (aw_take_w) begin
            awaddr_q <= {s_axi_awaddr[3:2], 2'h0};
         end
         if (w_take_w) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         aw_held_q <= (aw_held_q || aw_take_w) && !wr_fire_w;
         w_held_q <= (w_held_q || w_take_w) && !wr_fire_w;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_q && !aw_take_w && !s_axi_bvalid;
         s_axi_wready <= !w_held_q && !w_take_w && !s_axi_bvalid;
         if (wr_fire_w) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit_w ? RESP_OKAY : RESP_DECERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= !s_axi_rvalid && !ar_take_w;
         if (ar_take_w) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word_w;
            s_axi_rresp <= rd_hit_w ? RESP_OKAY : RESP_DECERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mcsr_q <= MCSR_RESET;
         cfg_long_q <= CFG_RESET;
      end else begin
         if (wr_mcsr_w) begin
            mcsr_q <= wdata_q[3:0];
         end
         if (wr_cfg_w) begin
            cfg_long_q <= wdata_q[CFG_LONG_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock divider
   logic slow_tick_w;
   psm_clk_div u_div (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .slow_en_i(mcsr_q[SMS_BIT]),
      .div_sel_i(mcsr_q[CPX_LSB +: 2]),
      .tick_o(slow_tick_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   // mode machine
   logic oie_w;
   logic halt_go_w;
   logic wdg_kill_w;
   logic wait_wake_w;
   logic ahalt_irq_w;
   logic halt_irq_w;
   logic stab_done_w;
   logic [STAB_W-1:0] stab_last_w;
   logic [STAB_W-1:0] stab_cnt_q;
   logic stab_rst_q;
   logic stab_rst_d;

   assign oie_w = mcsr_q[OIE_BIT];
   // watchdog reset only for plain halt, never for active-halt
   assign wdg_kill_w = halt_exec_i && !oie_w && wdg_active_i && !watchdog_halt_option_i;
   assign halt_go_w = halt_exec_i && !wdg_kill_w;
   assign wait_wake_w = irq_pending_i || ext_wake_w || ext_rst_w;
   // time base and clock safety only reach active-halt
   assign ahalt_irq_w = tb_irq_i || css_irq_i || ext_wake_w || irq_pending_i;
   assign halt_irq_w = ext_wake_w || irq_pending_i;
   assign stab_last_w = cfg_long_q ? STAB_W'(STAB_LONG_CYC - 1) : STAB_W'(STAB_SHORT_CYC - 1);
   assign stab_done_w = (stab_cnt_q == stab_last_w);

   always_comb begin
      mode_d = mode_q;
      stab_rst_d = stab_rst_q;
      case (mode_q)
         PM_RUN: begin
            if (wfi_exec_i) begin
               mode_d = PM_WAIT;
            end else if (halt_go_w) begin
               mode_d = oie_w ? PM_AHALT : PM_HALT;
            end
         end
         PM_WAIT: begin
            if (wait_wake_w) begin
               mode_d = PM_RUN;
            end
         end
         PM_AHALT: begin
            if (ext_rst_w) begin
               mode_d = PM_STAB;
               stab_rst_d = 1'b1;
            end else if (ahalt_irq_w) begin
               mode_d = PM_RUN;
            end
         end
         PM_HALT: begin
            if (ext_rst_w || halt_irq_w) begin
               mode_d = PM_STAB;
               stab_rst_d = ext_rst_w;
            end
         end
         PM_STAB: begin
            if (stab_done_w) begin
               mode_d = PM_RUN;
            end
         end
         default: begin
            mode_d = PM_RUN;
         end
      endcase
   end

   logic enter_sleep_w;
   logic wake_now_w;
   assign enter_sleep_w = (mode_q == PM_RUN) && (mode_d != PM_RUN);
   assign wake_now_w = (mode_q != PM_RUN) && (mode_q != PM_HALT) && (mode_d == PM_RUN);

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_q <= PM_RUN;
         stab_rst_q <= 1'b0;
         stab_cnt_q <= '0;
      end else begin
         mode_q <= mode_d;
         stab_rst_q <= stab_rst_d;
         stab_cnt_q <= (mode_q == PM_STAB) ? stab_cnt_q + 1'b1 : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cpu_clk_en_o <= 1'b0;
         periph_clk_en_o <= 1'b0;
         tb_clk_en_o <= 1'b0;
         osc_en_o <= 1'b1;
         mask_force_o <= 1'b0;
         mask_value_o <= MASK_ALL_EN;
         irq_service_o <= 1'b0;
         rst_vector_o <= 1'b0;
         wdg_reset_o <= 1'b0;
         mode_o <= 3'h0;
      end else begin
         cpu_clk_en_o <= (mode_d == PM_RUN) && slow_tick_w;
         // wait keeps the slow divider, giving slow-wait
         periph_clk_en_o <= ((mode_d == PM_RUN) || (mode_d == PM_WAIT)) && slow_tick_w;
         tb_clk_en_o <= (mode_d != PM_HALT) && (mode_d != PM_STAB);
         osc_en_o <= (mode_d != PM_HALT);
         mask_force_o <= enter_sleep_w;
         mask_value_o <= MASK_ALL_EN;
         // cpu pushes condition code on this pulse before the vector
         irq_service_o <= wake_now_w && !(mode_q == PM_STAB && stab_rst_q) && !ext_rst_w;
         rst_vector_o <= wake_now_w && ((mode_q == PM_STAB && stab_rst_q) || (mode_q == PM_WAIT && ext_rst_w));
         wdg_reset_o <= wdg_kill_w;
         mode_o <= mode_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   // helper: length of the current stabilising stretch, too long to unroll in a sequence
   logic [STAB_W-1:0] stab_len_q;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stab_len_q <= '0;
      end else begin
         stab_len_q <= (mode_q == PM_STAB) ? stab_len_q + 1'b1 : '0;
      end
   end

   a_wait_entry_mask: assert property ((mode_q == PM_RUN && wfi_exec_i) |=>
      mask_force_o && mode_o == 3'(PM_WAIT))
      else $error("wait entry did not force mask");
   a_halt_select_oie: assert property ((mode_q == PM_RUN && halt_go_w && !wfi_exec_i) |=>
      (mode_q == (oie_w ? PM_AHALT : PM_HALT)))
      else $error("halt instruction chose wrong mode");
   a_ahalt_fast_wake: assert property ((mode_q == PM_AHALT && tb_irq_i && !ext_rst_w) |=>
      irq_service_o && cpu_clk_en_o)
      else $error("active-halt interrupt exit delayed");
   a_halt_osc_off: assert property ((mode_q == PM_HALT) |-> !osc_en_o && !cpu_clk_en_o && !periph_clk_en_o)
      else $error("clocks running in halt");
   a_tb_no_halt_wake: assert property ((mode_q == PM_HALT && tb_irq_i && !halt_irq_w && !ext_rst_w) |=>
      mode_q == PM_HALT)
      else $error("time base ended halt");
   a_halt_wake_stab: assert property ((mode_q == PM_HALT && ext_wake_w && !ext_rst_w) |=> mode_q == PM_STAB)
      else $error("halt wake did not start stabilisation");
   a_stab_delay_len: assert property (((mode_q == PM_STAB) ##1 (mode_q == PM_RUN)) |->
      stab_len_q == (cfg_long_q ? STAB_W'(STAB_LONG_CYC) : STAB_W'(STAB_SHORT_CYC)))
      else $error("stabilisation length wrong");
   a_ahalt_periph_off: assert property ((mode_q == PM_AHALT) |-> tb_clk_en_o && osc_en_o && !periph_clk_en_o)
      else $error("active-halt clocks wrong");
   a_ahalt_no_wdg: assert property ((halt_exec_i && oie_w) |=> !wdg_reset_o)
      else $error("watchdog reset on active-halt");
   a_wdg_halt_rst: assert property ((mode_q == PM_RUN && !wfi_exec_i && halt_exec_i && !oie_w &&
      wdg_active_i && !watchdog_halt_option_i) |=> wdg_reset_o && mode_q == PM_RUN)
      else $error("halt with watchdog did not reset");
   // peripherals follow the divider in wait, so slow-wait keeps the reduced rate
   a_wait_periph_run: assert property ((mode_q == PM_WAIT && !wait_wake_w) |=>
      periph_clk_en_o == $past(slow_tick_w) && !cpu_clk_en_o)
      else $error("wait clocks wrong");
   a_reset_run: assert property ($rose(resetn_i) |-> mode_q == PM_RUN)
      else $error("not in run after reset");

   c_slow_wait: cover property (mode_q == PM_WAIT && mcsr_q[SMS_BIT]);
   c_ahalt_wake: cover property (mode_q == PM_AHALT ##1 irq_service_o);
   c_halt_rst: cover property (mode_q == PM_STAB && stab_rst_q ##1 rst_vector_o);
   c_wdg_kill: cover property (wdg_reset_o);
endmodule
`default_nettype wire

/* test/psm_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module psm_cpu_model
   import psm_pkg::*;
#(
   parameter logic [1:0] CC_RESET = 2'h3,
   parameter logic [1:0] ISR_LEVEL = 2'h3
)
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic cpu_clk_en_i,
   input wire logic mask_force_i,
   input wire logic [1:0] mask_value_i,
   input wire logic irq_service_i,
   input wire logic irq_req_i,
   output logic wfi_exec_o,
   output logic halt_exec_o,
   output logic irq_pending_o,
   output logic [1:0] cc_mask_o,
   output logic [1:0] cc_saved_o
);
   logic [1:0] cc_q;
   logic [1:0] saved_q;
   initial begin
      wfi_exec_o = 1'h0;
      halt_exec_o = 1'h0;
   end
   ////////////////////////////////////////////////////////////
   // an instruction only retires on an edge where the cpu clock is enabled
   task automatic exec(input logic is_halt);
      @(posedge core_clk_i);
      while (!cpu_clk_en_i) @(posedge core_clk_i);
      wfi_exec_o <= !is_halt;
      halt_exec_o <= is_halt;
      @(posedge core_clk_i);
      wfi_exec_o <= 1'h0;
      halt_exec_o <= 1'h0;
   endtask
   ////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cc_q <= CC_RESET;
         saved_q <= CC_RESET;
      end else if (irq_service_i) begin
         saved_q <= cc_q;
         cc_q <= ISR_LEVEL;
      end else if (mask_force_i) begin
         cc_q <= mask_value_i;
      end
   end
   // level 3 masks every request, so only a forced 10 lets it through
   assign irq_pending_o = irq_req_i && (cc_q != 2'h3);
   assign cc_mask_o = cc_q;
   assign cc_saved_o = saved_q;
endmodule
`default_nettype wire

/* test/psm_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module psm_ctrl_tb
   import psm_pkg::*;
   ();
   localparam logic [1:0] ISR_LVL = 2'h3;
   logic core_clk_i = 1'h0;
   logic resetn_i = 1'h0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wake = 4'h0, wstrb = 4'hF;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic irq_req = 1'h0, tb_irq = 1'h0, css_irq = 1'h0, wdg_on = 1'h0, wdg_opt = 1'h1, rst_req = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, wait_for_interrupt_instruction, halt, pend, cpu_en, per_en, tb_en, osc_en;
   logic force_m, isr, rst_vec, wdg_rst;
   logic [1:0] bresp, rresp, mval, cc, cc_sv, r;
   logic [31:0] rdata, d;
   logic [2:0] mode;
   int bad_count = 0;
   int checked = 0;
   int n;
   always #5 core_clk_i = ~core_clk_i;
   psm_ctrl u_psm_ctrl (
      .core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .wfi_exec_i(wait_for_interrupt_instruction), .halt_exec_i(halt), .irq_pending_i(pend), .tb_irq_i(tb_irq),
      .css_irq_i(css_irq), .wdg_active_i(wdg_on), .watchdog_halt_option_i(wdg_opt),
      .ext_wake_i(wake), .ext_rst_req_i(rst_req), .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en),
      .tb_clk_en_o(tb_en), .osc_en_o(osc_en), .mask_force_o(force_m), .mask_value_o(mval),
      .irq_service_o(isr), .rst_vector_o(rst_vec), .wdg_reset_o(wdg_rst), .mode_o(mode));
   psm_cpu_model #(.ISR_LEVEL(ISR_LVL)) u_psm_cpu_model (
      .core_clk_i(core_clk_i), .resetn_i(resetn_i), .cpu_clk_en_i(cpu_en), .mask_force_i(force_m),
      .mask_value_i(mval), .irq_service_i(isr), .irq_req_i(irq_req), .wfi_exec_o(wait_for_interrupt_instruction),
      .halt_exec_o(halt), .irq_pending_o(pend), .cc_mask_o(cc), .cc_saved_o(cc_sv));
   ////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge core_clk_i);
   endtask
   task automatic count(ref logic s, input int c);
      n = 0;
      repeat (c) begin
         tick(1);
         n += s;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         tick(1);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
      r = bresp;
      tick(1);
   endtask
   task automatic rd(input logic [3:0] a);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         tick(1);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h0;
      d = rdata;
      r = rresp;
      tick(1);
   endtask
   // bounded wait; a timeout shows up as a mode mismatch
   task automatic upto(input logic [2:0] m, input int lim);
      n = 0;
      while (mode !== m && n < lim) begin
         tick(1);
         n++;
      end
      chk(mode, m);
   endtask
   task automatic stab_done;
      upto(PM_RUN, 300);
      chk(n >= STAB_SHORT_CYC && n <= STAB_SHORT_CYC + 1, 1'h1);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      tick(6);
      chk({osc_en, mval, mode}, {1'h1, MASK_ALL_EN, 3'h0});
      resetn_i <= 1'h1;
      tick(2);
      chk({cpu_en, per_en, tb_en}, 3'h7);
      rd(REG_CFG_OFS);
      chk(d, 32'(CFG_RESET));
      rd(REG_MCSR_OFS);
      chk(d, 32'(MCSR_RESET));
      // low byte strobe off: the write is answered but must not land
      wstrb <= 4'hE;
      wr(REG_MCSR_OFS, 32'hF);
      chk(r, RESP_OKAY);
      wstrb <= 4'hF;
      rd(REG_MCSR_OFS);
      chk(d, 32'(MCSR_RESET));
      wr(4'hC, 32'hF);
      chk(r, RESP_DECERR);
      rd(4'hC);
      chk(r, RESP_DECERR);
      chk(d, 32'h0);
      for (int k = 0; k < 4; k++) begin
         wr(REG_MCSR_OFS, 32'(1 + 2 * k));
         tick(4);
         count(cpu_en, 32);
         chk(n, 32 >> (k + 1));
      end
      u_psm_cpu_model.exec(1'h0);
      upto(PM_WAIT, 40);
      rd(REG_STAT_OFS);
      chk(d[STAT_SLOW_BIT:STAT_MODE_LSB], {1'h1, 1'h1, PM_WAIT});
      chk(cc, MASK_ALL_EN);
      count(cpu_en, 16);
      chk(n, 0);
      irq_req <= 1'h1;
      upto(PM_RUN, 8);
      tick(1);
      chk({cc_sv, cc}, {MASK_ALL_EN, ISR_LVL});
      wr(REG_MCSR_OFS, 32'h0);
      wr(REG_CFG_OFS, 32'h0);
      // request still raised but masked; only the entry force can wake
      u_psm_cpu_model.exec(1'h1);
      tick(1);
      chk({mode, osc_en, cpu_en, per_en, force_m}, {PM_HALT, 4'h1});
      upto(PM_STAB, 8);
      chk(osc_en, 1'h1);
      stab_done();
      tick(1);
      chk(cc, ISR_LVL);
      irq_req <= 1'h0;
      css_irq <= 1'h1;
      tb_irq <= 1'h1;
      u_psm_cpu_model.exec(1'h1);
      tick(20);
      chk(mode, PM_HALT);
      css_irq <= 1'h0;
      tb_irq <= 1'h0;
      wake <= 4'h8;
      upto(PM_STAB, 8);
      wake <= 4'h0;
      stab_done();
      wr(REG_MCSR_OFS, 32'h8);
      wdg_on <= 1'h1;
      wdg_opt <= 1'h0;
      u_psm_cpu_model.exec(1'h1);
      tick(1);
      chk({mode, osc_en, tb_en, per_en, wdg_rst}, {PM_AHALT, 4'hC});
      tb_irq <= 1'h1;
      upto(PM_RUN, 8);
      tb_irq <= 1'h0;
      u_psm_cpu_model.exec(1'h1);
      upto(PM_AHALT, 4);
      rst_req <= 1'h1;
      upto(PM_STAB, 8);
      rst_req <= 1'h0;
      stab_done();
      chk(rst_vec, 1'h1);
      wr(REG_MCSR_OFS, 32'h0);
      u_psm_cpu_model.exec(1'h1);
      count(wdg_rst, 4);
      chk(n, 1);
      resetn_i <= 1'h0;
      tick(2);
      resetn_i <= 1'h1;
      tick(2);
      chk({mode, cpu_en}, 4'h1);
      complete_run();
   end
   initial begin
      #200000;
      bad_count++;
      complete_run();
   end
endmodule
`default_nettype wire
